//--- hw/iosv_pkg.sv
package iosv_pkg;
  // timebase
  localparam int CLK_PERIOD_NS = 20;
  localparam int HUND_PERIOD_NS = 10000000;
  localparam int HUND_CYCLES_DFLT = HUND_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MIN_HUNDREDTHS = 6000;
  // limits of the reminder intervals, minutes
  localparam logic [9:0] REM_DELAY_MAX = 10'h3e8;
  localparam logic [9:0] REM_INT_MAX = 10'h3e7;
  // timer input indices
  localparam int NUM_IN = 5;
  localparam int IN_TACHO = 0;
  localparam int IN_GATE = 1;
  localparam int IN_RCONF = 2;
  localparam int IN_PCONF = 3;
  localparam int IN_AUX = 4;
  // register byte offsets
  localparam int AXI_AW = 6;
  localparam logic [AXI_AW-1:0] OFS_INCFG = 6'h00;
  localparam logic [AXI_AW-1:0] OFS_REMCFG = 6'h04;
  localparam logic [AXI_AW-1:0] OFS_CHKCFG = 6'h08;
  localparam logic [AXI_AW-1:0] OFS_AUXCFG = 6'h0c;
  localparam logic [AXI_AW-1:0] OFS_REJCFG = 6'h10;
  localparam logic [AXI_AW-1:0] OFS_PCDLY = 6'h14;
  localparam logic [AXI_AW-1:0] OFS_IRQSTAT = 6'h18;
  localparam logic [AXI_AW-1:0] OFS_IRQMASK = 6'h1c;
  localparam logic [AXI_AW-1:0] OFS_STATE = 6'h20;
  // field positions
  localparam int IN_EN_LSB = 0;
  localparam int IN_POL_LSB = 8;
  localparam int GATE_TRAIL_BIT = 16;
  localparam int VAR_SPEED_BIT = 17;
  localparam int REM_DELAY_LSB = 0;
  localparam int REM_INT_LSB = 16;
  localparam int REM_EN_BIT = 31;
  localparam int AUX_SEL_LSB = 16;
  localparam int REJ_DUR_LSB = 16;
  // writable bits and reset values
  localparam logic [31:0] MASK_INCFG = 32'h0003_1f1f;
  localparam logic [31:0] MASK_REMCFG = 32'h83ff_03ff;
  localparam logic [31:0] MASK_CHKCFG = 32'h0000_ffff;
  localparam logic [31:0] MASK_AUXCFG = 32'h0007_ffff;
  localparam logic [31:0] MASK_REJCFG = 32'hffff_ffff;
  localparam logic [31:0] MASK_PCDLY = 32'h0000_ffff;
  localparam logic [31:0] RST_INCFG = 32'h0000_0000;
  localparam logic [31:0] RST_REMCFG = 32'h8014_0078;
  localparam logic [31:0] RST_CHKCFG = 32'h0000_0064;
  localparam logic [31:0] RST_AUXCFG = 32'h0000_00c8;
  localparam logic [31:0] RST_REJCFG = 32'h0032_0000;
  localparam logic [31:0] RST_PCDLY = 32'h0000_0000;
  // interrupt events
  localparam int NUM_EVT = 5;
  localparam int EVT_WARN = 0;
  localparam int EVT_OVERDUE = 1;
  localparam int EVT_CONFIRM = 2;
  localparam int EVT_AUX = 3;
  localparam int EVT_REJECT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    AUX_NONE = 3'h0, AUX_WARN = 3'h1, AUX_FAULT = 3'h2, AUX_REJECT = 3'h3, AUX_ALARM = 3'h4
  } iosv_aux_sel_e;

  typedef enum logic [3:0] {
    REM_IDLE = 4'b0001, REM_COUNT = 4'b0010, REM_WARN = 4'b0100, REM_OVERDUE = 4'b1000
  } iosv_rem_e;

  typedef struct packed {
    logic [AXI_AW-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [AXI_AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } iosv_axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } iosv_axil_rsp_s;
endpackage

//--- hw/iosv_input_cond.sv
`timescale 1ns/100ps
module iosv_input_cond #(
  parameter int N = 5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // pins and settings
  input wire logic [N-1:0] pinRaw,
  input wire logic [N-1:0] inEn,
  input wire logic [N-1:0] inPolLow,
  // conditioned view
  output logic [N-1:0] level,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);
  logic [N-1:0] sync1_ff, sync2_ff, level_ff, prev_ff;

  if (N < 1) begin : g_chk
    $error("iosv_input_cond needs at least one input");
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pinRaw;
      sync2_ff <= sync1_ff;
    end
  end

  // a disabled input reads as idle to everything downstream
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      level_ff <= '0;
      prev_ff <= '0;
    end else begin
      level_ff <= inEn & (sync2_ff ^ inPolLow); // [RL5] [RL7]
      prev_ff <= level_ff;
    end
  end

  assign level = level_ff;
  assign rise = level_ff & ~prev_ff;
  assign fall = ~level_ff & prev_ff;
endmodule

//--- hw/iosv_down_timer.sv
`timescale 1ns/100ps
module iosv_down_timer #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // control
  input wire logic load,
  input wire logic stop,
  input wire logic tick,
  input wire logic [WIDTH-1:0] value,
  // status
  output logic running,
  output logic expire
);
  logic [WIDTH-1:0] cnt_ff;
  logic running_ff, expire_ff;

  if (WIDTH < 2) begin : g_chk
    $error("iosv_down_timer needs WIDTH of at least 2");
  end

  // zero is served as one tick so no interval is shorter than a unit
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
      running_ff <= 1'b0;
      expire_ff <= 1'b0;
    end else begin
      expire_ff <= 1'b0;
      if (stop) begin
        running_ff <= 1'b0;
      end else if (load) begin
        cnt_ff <= (value == '0) ? WIDTH'(1) : value;
        running_ff <= 1'b1;
      end else if (running_ff && tick) begin
        if (cnt_ff == WIDTH'(1)) begin
          running_ff <= 1'b0;
          expire_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - WIDTH'(1);
        end
      end
    end
  end

  assign running = running_ff;
  assign expire = expire_ff;
endmodule

//--- hw/iosv_supervisor.sv
// Summary of operation
// RL1: reminder has enable and 1-1000 minute delay
// RL2: delay expiry raises warning relay, inspection continues
// RL3: further interval raises fault relay, flags overdue
// RL4: select-key acknowledge clears the overdue flag
// RL5: per-input enable and polarity; disabled inputs ignored
// RL6: five conditioned inputs: tacho, gate, confirms, aux
// RL7: polarity set so idle reads 0, blocked 1
// RL8: gating photocell triggers on chosen edge
// RL9: reject starts two confirm check timers
// RL10: missed confirm latches fault until detector reset
// RL11: only enabled confirm inputs can cause faults
// RL12: aux must stay active for active time
// RL13: aux drives one of five relay choices
// RL14: delays in tacho pulses or hundredths
// RL15: prescaled timebase; counters clear; reminder runs from reset
`timescale 1ns/100ps
module iosv_supervisor #(
  parameter int HUND_CYCLES = iosv_pkg::HUND_CYCLES_DFLT,
  parameter int MIN_HUND = iosv_pkg::MIN_HUNDREDTHS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register bus
  input wire iosv_pkg::iosv_axil_req_s axiReq,
  output iosv_pkg::iosv_axil_rsp_s axiRsp,
  // field pins
  input wire logic [iosv_pkg::NUM_IN-1:0] timerPinRaw,
  input wire logic selectKeyIn,
  input wire logic detResetIn,
  // from detection logic
  input wire logic metalDetect,
  // relays and flags
  output logic warnRelay,
  output logic faultRelay,
  output logic rejectRelay,
  output logic alarmRelay,
  output logic sampleOverdue,
  output logic irq
);
  import iosv_pkg::*;

  localparam int HW = $clog2(HUND_CYCLES);
  localparam int MW = $clog2(MIN_HUND);

  if (HUND_CYCLES < 2 || MIN_HUND < 2) begin : g_chk
    $error("iosv_supervisor timebase counts must be at least 2");
  end

  function automatic logic [31:0] strbMask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic [31:0] wrMerge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] strb, input logic [31:0] msk);
    logic [31:0] m;
    m = strbMask(strb) & msk;
    return (old & ~m) | (dat & m);
  endfunction

  function automatic logic [9:0] clampMax(input logic [9:0] v, input logic [9:0] mx);
    return (v > mx) ? mx : v;
  endfunction

  // bus slave
  logic awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff;
  logic [AXI_AW-1:0] awAddr_ff;
  logic [31:0] wData_ff, rdata_ff, rdMux;
  logic [3:0] wStrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic doWrite, awTake, wTake, arTake, rdHit, wrHit;

  assign awTake = axiReq.awvalid && !awHeld_ff && !bvalid_ff;
  assign wTake = axiReq.wvalid && !wHeld_ff && !bvalid_ff;
  assign arTake = axiReq.arvalid && !rvalid_ff;
  assign doWrite = awHeld_ff && wHeld_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= '0;
      wStrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (awTake) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= axiReq.awaddr;
      end
      if (wTake) begin
        wHeld_ff <= 1'b1;
        wData_ff <= axiReq.wdata;
        wStrb_ff <= axiReq.wstrb;
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (axiReq.bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // configuration registers
  logic [31:0] inCfg_ff, remCfg_ff, chkCfg_ff, auxCfg_ff, rejCfg_ff, pcDly_ff;
  logic [NUM_EVT-1:0] stat_ff, mask_ff, evt, statClr;
  logic [AXI_AW-1:0] wa;

  assign wa = {awAddr_ff[AXI_AW-1:2], 2'b00};
  assign wrHit = (wa <= OFS_IRQMASK);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      inCfg_ff <= RST_INCFG;
      remCfg_ff <= RST_REMCFG;
      chkCfg_ff <= RST_CHKCFG;
      auxCfg_ff <= RST_AUXCFG;
      rejCfg_ff <= RST_REJCFG;
      pcDly_ff <= RST_PCDLY;
      mask_ff <= '0;
    end else if (doWrite) begin
      unique case (wa)
        OFS_INCFG: inCfg_ff <= wrMerge(inCfg_ff, wData_ff, wStrb_ff, MASK_INCFG);
        OFS_REMCFG: remCfg_ff <= wrMerge(remCfg_ff, wData_ff, wStrb_ff, MASK_REMCFG);
        OFS_CHKCFG: chkCfg_ff <= wrMerge(chkCfg_ff, wData_ff, wStrb_ff, MASK_CHKCFG);
        OFS_AUXCFG: auxCfg_ff <= wrMerge(auxCfg_ff, wData_ff, wStrb_ff, MASK_AUXCFG);
        OFS_REJCFG: rejCfg_ff <= wrMerge(rejCfg_ff, wData_ff, wStrb_ff, MASK_REJCFG);
        OFS_PCDLY: pcDly_ff <= wrMerge(pcDly_ff, wData_ff, wStrb_ff, MASK_PCDLY);
        OFS_IRQMASK: mask_ff <= NUM_EVT'(wrMerge({27'h0, mask_ff}, wData_ff, wStrb_ff,
                                                 32'h0000_001f));
        default: ;
      endcase
    end
  end

  // write-one-to-clear, a new event in the same cycle survives
  assign statClr = (doWrite && wa == OFS_IRQSTAT) ?
                   NUM_EVT'(wData_ff & strbMask(wStrb_ff)) : '0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stat_ff <= '0;
      irq <= 1'b0;
    end else begin
      stat_ff <= (stat_ff & ~statClr) | evt;
      irq <= |(stat_ff & mask_ff);
    end
  end

  // field views
  logic [NUM_IN-1:0] inEn, condLvl, condRise, condFall;
  logic gateTrail, varSpeed, remEn;
  logic [9:0] remDelay, remInt;
  iosv_aux_sel_e auxSel;

  assign inEn = inCfg_ff[IN_EN_LSB +: NUM_IN];
  assign gateTrail = inCfg_ff[GATE_TRAIL_BIT];
  assign varSpeed = inCfg_ff[VAR_SPEED_BIT];
  assign remEn = remCfg_ff[REM_EN_BIT];
  assign remDelay = clampMax(remCfg_ff[REM_DELAY_LSB +: 10], REM_DELAY_MAX); // [RL1]
  assign remInt = clampMax(remCfg_ff[REM_INT_LSB +: 10], REM_INT_MAX);
  assign auxSel = iosv_aux_sel_e'(auxCfg_ff[AUX_SEL_LSB +: 3]);

  // five inputs only; the sixth timer input is left out on purpose
  iosv_input_cond #(.N(NUM_IN)) u_cond ( // [RL5] [RL6]
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pinRaw(timerPinRaw),
    .inEn(inEn),
    .inPolLow(inCfg_ff[IN_POL_LSB +: NUM_IN]),
    .level(condLvl),
    .rise(condRise),
    .fall(condFall)
  );

  // operator pins
  logic selS1_ff, selS2_ff, selPrev_ff, rstS1_ff, rstS2_ff, selAck, detRst;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      selS1_ff <= 1'b0;
      selS2_ff <= 1'b0;
      selPrev_ff <= 1'b0;
      rstS1_ff <= 1'b0;
      rstS2_ff <= 1'b0;
    end else begin
      selS1_ff <= selectKeyIn;
      selS2_ff <= selS1_ff;
      selPrev_ff <= selS2_ff;
      rstS1_ff <= detResetIn;
      rstS2_ff <= rstS1_ff;
    end
  end

  assign selAck = selS2_ff && !selPrev_ff;
  assign detRst = rstS2_ff;

  // timebase
  logic [HW-1:0] hundCnt_ff;
  logic [MW-1:0] minCnt_ff;
  logic hundTick, minTick;

  assign hundTick = (hundCnt_ff == HW'(HUND_CYCLES - 1));
  assign minTick = hundTick && (minCnt_ff == MW'(MIN_HUND - 1));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hundCnt_ff <= '0;
      minCnt_ff <= '0;
    end else begin
      hundCnt_ff <= hundTick ? '0 : hundCnt_ff + HW'(1); // [RL15]
      if (hundTick) begin
        minCnt_ff <= minTick ? '0 : minCnt_ff + MW'(1);
      end
    end
  end

  // sample test reminder
  iosv_rem_e remState_ff, nxt_remState;
  logic remLoad, remStop, remExpire;
  logic [9:0] remValue;

  always_comb begin
    nxt_remState = remState_ff;
    remLoad = 1'b0;
    remValue = remDelay;
    unique case (remState_ff)
      REM_IDLE: begin
        if (remEn) begin
          nxt_remState = REM_COUNT;
          remLoad = 1'b1;
        end
      end
      REM_COUNT: begin
        if (!remEn) begin
          nxt_remState = REM_IDLE;
        end else if (remExpire) begin
          nxt_remState = REM_WARN; // [RL2]
          remLoad = 1'b1;
          remValue = remInt;
        end
      end
      REM_WARN: begin
        if (!remEn) begin
          nxt_remState = REM_IDLE;
        end else if (selAck) begin
          nxt_remState = REM_COUNT;
          remLoad = 1'b1;
        end else if (remExpire) begin
          nxt_remState = REM_OVERDUE; // [RL3]
        end
      end
      REM_OVERDUE: begin
        if (!remEn) begin
          nxt_remState = REM_IDLE;
        end else if (selAck) begin
          nxt_remState = REM_COUNT; // [RL4]
          remLoad = 1'b1;
        end
      end
    endcase
  end

  assign remStop = (nxt_remState == REM_IDLE);

  // reset leaves IDLE and starts counting at once when enabled
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      remState_ff <= REM_IDLE; // [RL15]
    end else begin
      remState_ff <= nxt_remState;
    end
  end

  iosv_down_timer #(.WIDTH(10)) u_rem (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .load(remLoad),
    .stop(remStop),
    .tick(minTick),
    .value(remValue),
    .running(),
    .expire(remExpire)
  );

  // reject sequence; gated systems start from the chosen photocell edge
  logic gateEn, gateTrig, metalPend_ff, rejStart, unitTick, dlyExpire, durRun, rejRise;
  logic rejPrev_ff;

  assign gateEn = inEn[IN_GATE];
  assign gateTrig = gateTrail ? condFall[IN_GATE] : condRise[IN_GATE]; // [RL8]
  assign rejStart = gateEn ? (gateTrig && (metalPend_ff || metalDetect)) : metalDetect;
  assign unitTick = varSpeed ? condRise[IN_TACHO] : hundTick; // [RL14]

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      metalPend_ff <= 1'b0;
    end else if (rejStart || !gateEn) begin
      metalPend_ff <= 1'b0;
    end else if (metalDetect) begin
      metalPend_ff <= 1'b1;
    end
  end

  iosv_down_timer #(.WIDTH(16)) u_rej_dly (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .load(rejStart),
    .stop(1'b0),
    .tick(unitTick),
    .value(gateEn ? pcDly_ff[15:0] : rejCfg_ff[15:0]), // [RL14]
    .running(),
    .expire(dlyExpire)
  );

  iosv_down_timer #(.WIDTH(16)) u_rej_dur (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .load(dlyExpire),
    .stop(1'b0),
    .tick(hundTick),
    .value(rejCfg_ff[REJ_DUR_LSB +: 16]),
    .running(durRun),
    .expire()
  );

  // confirm check timers
  logic rcRun, rcExp, pcExp, faultLatch_ff, confirmFault;

  assign rejRise = rejectRelay && !rejPrev_ff;

  iosv_down_timer #(.WIDTH(16)) u_chk_rc (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .load(rejRise), // [RL9]
    .stop(condLvl[IN_RCONF]),
    .tick(hundTick),
    .value(chkCfg_ff[15:0]),
    .running(rcRun),
    .expire(rcExp)
  );

  iosv_down_timer #(.WIDTH(16)) u_chk_pc (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .load(rejRise), // [RL9]
    .stop(condLvl[IN_PCONF]),
    .tick(hundTick),
    .value(chkCfg_ff[15:0]),
    .running(),
    .expire(pcExp)
  );

  assign confirmFault = (rcExp && inEn[IN_RCONF]) || (pcExp && inEn[IN_PCONF]); // [RL11]

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      faultLatch_ff <= 1'b0;
      rejPrev_ff <= 1'b0;
    end else begin
      rejPrev_ff <= rejectRelay;
      if (confirmFault) begin
        faultLatch_ff <= 1'b1; // [RL10]
      end else if (detRst) begin
        faultLatch_ff <= 1'b0;
      end
    end
  end

  // auxiliary qualification
  logic auxAct, auxRun, auxExp, auxQual_ff;

  assign auxAct = condLvl[IN_AUX];

  iosv_down_timer #(.WIDTH(16)) u_aux (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .load(auxAct && !auxRun && !auxQual_ff && !auxExp),
    .stop(!auxAct), // [RL12]
    .tick(hundTick),
    .value(auxCfg_ff[15:0]),
    .running(auxRun),
    .expire(auxExp)
  );

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      auxQual_ff <= 1'b0;
    end else if (!auxAct) begin
      auxQual_ff <= 1'b0; // [RL12]
    end else if (auxExp) begin
      auxQual_ff <= 1'b1;
    end
  end

  // relay drivers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      warnRelay <= 1'b0;
      faultRelay <= 1'b0;
      rejectRelay <= 1'b0;
      alarmRelay <= 1'b0;
      sampleOverdue <= 1'b0;
    end else begin
      warnRelay <= (remState_ff == REM_WARN) || (remState_ff == REM_OVERDUE) ||
                   (auxQual_ff && auxSel == AUX_WARN); // [RL2] [RL13]
      faultRelay <= faultLatch_ff || (remState_ff == REM_OVERDUE) ||
                    (auxQual_ff && auxSel == AUX_FAULT); // [RL3] [RL10]
      rejectRelay <= durRun || (auxQual_ff && auxSel == AUX_REJECT);
      alarmRelay <= auxQual_ff && auxSel == AUX_ALARM; // [RL13]
      sampleOverdue <= (remState_ff == REM_OVERDUE); // [RL4]
    end
  end

  assign evt[EVT_WARN] = (remState_ff == REM_COUNT) && (nxt_remState == REM_WARN);
  assign evt[EVT_OVERDUE] = (remState_ff == REM_WARN) && (nxt_remState == REM_OVERDUE);
  assign evt[EVT_CONFIRM] = confirmFault;
  assign evt[EVT_AUX] = auxExp && auxAct;
  assign evt[EVT_REJECT] = rejRise;

  // register read
  always_comb begin
    rdHit = 1'b1;
    unique case ({axiReq.araddr[AXI_AW-1:2], 2'b00})
      OFS_INCFG: rdMux = inCfg_ff;
      OFS_REMCFG: rdMux = remCfg_ff;
      OFS_CHKCFG: rdMux = chkCfg_ff;
      OFS_AUXCFG: rdMux = auxCfg_ff;
      OFS_REJCFG: rdMux = rejCfg_ff;
      OFS_PCDLY: rdMux = pcDly_ff;
      OFS_IRQSTAT: rdMux = {27'h0, stat_ff};
      OFS_IRQMASK: rdMux = {27'h0, mask_ff};
      OFS_STATE: rdMux = {12'h0, remState_ff, 1'b0, faultLatch_ff, auxQual_ff,
                          sampleOverdue, alarmRelay, rejectRelay, faultRelay, warnRelay,
                          3'h0, condLvl};
      default: begin
        rdMux = 32'h0;
        rdHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (arTake) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rdMux;
      rresp_ff <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (axiReq.rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign axiRsp.awready = !awHeld_ff && !bvalid_ff;
  assign axiRsp.wready = !wHeld_ff && !bvalid_ff;
  assign axiRsp.bvalid = bvalid_ff;
  assign axiRsp.bresp = bresp_ff;
  assign axiRsp.arready = !rvalid_ff;
  assign axiRsp.rvalid = rvalid_ff;
  assign axiRsp.rdata = rdata_ff;
  assign axiRsp.rresp = rresp_ff;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_warn_relay_on: assert property (remState_ff == REM_WARN |=> warnRelay) // [RL2]
    else $error("warning relay off while reminder warns");
  a_overdue_fault: assert property (remState_ff == REM_OVERDUE |=> // [RL3]
                                    faultRelay && sampleOverdue)
    else $error("overdue without fault relay");
  a_ack_clears: assert property (remState_ff == REM_OVERDUE && selAck && remEn |-> // [RL4]
                                 ##2 !sampleOverdue)
    else $error("acknowledge did not clear overdue");
  a_disabled_idle: assert property (##1 (condLvl & ~$past(inEn)) == '0) // [RL5]
    else $error("disabled input seen active");
  a_check_start: assert property (rejRise && !condLvl[IN_RCONF] |=> rcRun) // [RL9]
    else $error("check timer not started on reject");
  a_fault_latched: assert property (faultLatch_ff && !detRst |=> faultLatch_ff) // [RL10]
    else $error("fault latch dropped without reset");
  a_disabled_nofault: assert property (!faultLatch_ff && // [RL11]
                                       !inEn[IN_RCONF] && !inEn[IN_PCONF] |=> !faultLatch_ff)
    else $error("fault from disabled confirm input");
  a_aux_restart: assert property (!auxAct |=> !auxQual_ff && !auxRun) // [RL12]
    else $error("aux qualification survived inactive sample");
  a_aux_alarm: assert property (auxQual_ff && auxSel == AUX_NONE |=> !alarmRelay) // [RL13]
    else $error("aux none still drives a relay");
  a_stat_set_wins: assert property (evt[EVT_CONFIRM] |=> stat_ff[EVT_CONFIRM])
    else $error("interrupt event lost");
  a_bvalid_hold: assert property (bvalid_ff && !axiReq.bready |=> bvalid_ff)
    else $error("write response dropped early");

  c_overdue: cover property (remState_ff == REM_WARN ##1 remState_ff == REM_OVERDUE);
  c_confirm_fault: cover property (confirmFault);
  c_aux_qual: cover property ($rose(auxQual_ff));
  c_reject: cover property (rejRise ##[1:20] !rejectRelay);
endmodule

//--- sim/iosv_field_model.sv
`timescale 1ns/100ps
module iosv_field_model (
  // sensor state and wiring sense
  input wire logic [4:0] blocked,
  input wire logic [4:0] polLow,
  // pins
  output logic [4:0] pinRaw
);
  // active-low sensors idle high
  assign pinRaw = blocked ^ polLow;
endmodule

//--- sim/iosv_supervisor_tb.sv
`timescale 1ns/100ps
module iosv_supervisor_tb;
  import iosv_pkg::*;
  logic clk_sys = 0, arst_n = 0, selKey = 0, detRst = 0, metal = 0;
  logic warn, fault, rej, alarm, overdue, irq;
  logic [4:0] blocked = 0, polLow = 0, pinRaw;
  logic [31:0] rd;
  logic [1:0] rs;
  int errors = 0, compares = 0, n, k;
  iosv_axil_req_s req = '0;
  iosv_axil_rsp_s rsp;
  logic [5:0] ofs [4] = '{OFS_INCFG, OFS_REMCFG, OFS_CHKCFG, OFS_AUXCFG};
  logic [31:0] dflt [4] = '{RST_INCFG, RST_REMCFG, RST_CHKCFG, RST_AUXCFG};
  iosv_supervisor #(.HUND_CYCLES(4), .MIN_HUND(3)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .axiReq(req), .axiRsp(rsp), .timerPinRaw(pinRaw), .selectKeyIn(selKey),
    .detResetIn(detRst), .metalDetect(metal), .warnRelay(warn), .faultRelay(fault),
    .rejectRelay(rej), .alarmRelay(alarm), .sampleOverdue(overdue), .irq(irq));
  iosv_field_model fld_u (.blocked(blocked), .polLow(polLow), .pinRaw(pinRaw));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic give_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait; a miss ends the run
  task automatic wt(ref logic s, input logic v, input int lim);
    for (n = 0; n < lim && s !== v; n++) @(posedge clk_sys);
    chk(s, v);
    if (s !== v) give_verdict();
  endtask
  task automatic bus(input logic wrOp, input logic [5:0] a, input logic [31:0] d);
    if (wrOp) req <= '{a, 1'b1, d, 4'hf, 1'b1, 1'b1, 6'h0, 1'b0, 1'b0};
    else req <= '{6'h0, 1'b0, 32'h0, 4'h0, 1'b0, 1'b0, a, 1'b1, 1'b1};
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
      rd = rsp.rdata;
      rs = wrOp ? rsp.bresp : rsp.rresp;
      if ((wrOp ? rsp.bvalid : rsp.rvalid) === 1'b1) break;
    end
    chk(n < 50, 1);
    if (n == 50) give_verdict();
    req <= '0;
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    for (k = 0; k < 4; k++) begin
      bus(0, ofs[k], 0);
      chk(rd, dflt[k]);
    end
    bus(0, 6'h3c, 0);
    chk(rs, RESP_SLVERR);
    chk(rd, 32'h0);
    bus(1, OFS_IRQMASK, 32'h1);
    chk(rs, RESP_OKAY);
    // running count keeps its old load, so cycle the enable
    bus(1, OFS_REMCFG, 32'h0001_0001);
    bus(1, OFS_REMCFG, 32'h8001_0001);
    wt(warn, 1, 100);
    chk({fault, overdue, irq}, 3'h1);
    wt(fault, 1, 100);
    chk({warn, overdue, irq}, 3'h7);
    selKey <= 1'b1;
    wt(overdue, 0, 10);
    selKey <= 1'b0;
    bus(1, OFS_REMCFG, 0);
    bus(1, OFS_IRQSTAT, 32'h1f);
    repeat (3) @(posedge clk_sys);
    chk({warn, fault, irq}, 0);
    bus(1, OFS_CHKCFG, 32'h5);
    bus(1, OFS_REJCFG, 32'h0002_0000);
    // disabled, confirmed through active-low pin, then missed
    for (k = 0; k < 3; k++) begin
      polLow <= {2'h0, k == 1, 2'h0};
      blocked <= {2'h0, k == 1, 2'h0};
      bus(1, OFS_INCFG, {21'h0, k == 1, 7'h0, k > 0, 2'h0});
      metal <= 1'b1;
      @(posedge clk_sys);
      metal <= 1'b0;
      wt(rej, 1, 50);
      wt(rej, 0, 50);
      repeat (40) @(posedge clk_sys);
      chk(fault, k == 2);
      detRst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      wt(fault, 0, 20);
      detRst <= 1'b0;
    end
    // gated reject on the trailing edge, delay counted in tacho pulses
    bus(1, OFS_INCFG, 32'h0003_0003);
    metal <= 1'b1;
    @(posedge clk_sys);
    metal <= 1'b0;
    blocked <= 5'h02;
    repeat (20) @(posedge clk_sys);
    chk(rej, 0);
    blocked <= 5'h00;
    repeat (20) @(posedge clk_sys);
    chk(rej, 0);
    blocked <= 5'h01;
    wt(rej, 1, 50);
    wt(rej, 0, 50);
    bus(1, OFS_INCFG, 32'h10);
    // one short drop must restart qualification
    for (k = 0; k < 5; k++) begin
      bus(1, OFS_AUXCFG, {13'h0, k[2:0], 16'h3});
      blocked <= 5'h10;
      repeat (8) @(posedge clk_sys);
      blocked <= 5'h00;
      @(posedge clk_sys);
      blocked <= 5'h10;
      repeat (8) @(posedge clk_sys);
      chk({alarm, rej, fault, warn}, 0);
      repeat (20) @(posedge clk_sys);
      chk({alarm, rej, fault, warn}, (k == 0) ? 0 : 1 << (k - 1));
      blocked <= 5'h00;
      detRst <= 1'b1;
      repeat (10) @(posedge clk_sys);
      detRst <= 1'b0;
    end
    give_verdict();
  end
endmodule
